// *** rtl/ebu_pkg.sv ***
package ebu_pkg;

	// address and data widths
	localparam int ADDR_W = 22;
	localparam int DATA_W = 16;
	localparam int HALF_W = 8;
	localparam int NWIN   = 4;
	localparam int NCS    = 4;
	localparam int UPPER_W = 6;

	// bus modes: single chip plus four external bus modes
	typedef enum logic [2:0] {
		EBU_MODE_SINGLE   = 3'h0,
		EBU_MODE_DEMUX16  = 3'h1,
		EBU_MODE_MUX16    = 3'h2,
		EBU_MODE_MUX8     = 3'h3,
		EBU_MODE_DEMUX8   = 3'h4
	} ebu_mode_t;

	// address space restriction
	typedef enum logic [1:0] {
		EBU_SPACE_4M   = 2'h0,
		EBU_SPACE_1M   = 2'h1,
		EBU_SPACE_256K = 2'h2,
		EBU_SPACE_64K  = 2'h3
	} ebu_space_t;

	// number of upper address lines per space setting
	localparam logic [2:0] UPPER_4M   = 3'h6;
	localparam logic [2:0] UPPER_1M   = 3'h4;
	localparam logic [2:0] UPPER_256K = 3'h2;
	localparam logic [2:0] UPPER_64K  = 3'h0;
	localparam int UPPER_LSB = 16;

	// bus configuration: mode plus four timing fields, in cycles
	typedef struct packed {
		ebu_mode_t  mode;
		logic [3:0] wait_cyc;    // memory cycle time
		logic [1:0] tri_cyc;     // data tri-state time
		logic [1:0] ale_cyc;     // address latch pulse length
		logic [1:0] strobe_dly;  // read/write strobe delay
	} ebu_cfg_t;

	// address window: base and size mask on the upper 12 address bits
	localparam int WIN_LSB = 10;
	localparam int WIN_W   = 12;
	typedef struct packed {
		logic              enable;
		logic [WIN_W-1:0]  base;
		logic [WIN_W-1:0]  mask;   // set bits are compared
	} ebu_win_t;

	// request from the core
	typedef struct packed {
		logic              valid;
		logic              write;
		logic              fetch;
		logic [1:0]        be;     // byte enables, bit 0 is low byte
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} ebu_req_t;

	// system configuration bits
	typedef struct packed {
		logic       low_byte_store_mode;  // store strobe select bit
		logic       unlatched_select_bit; // chip select mode
		ebu_space_t space;
	} ebu_sys_t;

	// reset values
	localparam logic [1:0]  BE_NONE   = 2'h0;
	localparam logic [3:0]  CNT_ONE   = 4'h1;
	localparam logic [3:0]  CNT_ZERO  = 4'h0;
	localparam logic [NCS-1:0] CS_IDLE = 4'hf;

endpackage : ebu_pkg

// *** rtl/ebu_ctrl.sv ***
`timescale 1ns/1ns
`default_nettype none

// Function
// (R1) read strobe active for every external fetch or data read
// (R2) plain store mode pulses store strobe on every external write
// (R3) low-byte mode strobes only low-byte writes on 16-bit, all on 8-bit
// (R4) multiplexed modes emit an address latch pulse
// (R5) external fetch select sampled at reset; low means fetch externally
// (R6) primary pins have per-bit direction; input bits are not driven; applied only while idle, bus cycles drive the pins per mode
// (R7) demultiplexed: address on secondary pins, data on primary pins
// (R8) multiplexed: primary pins share address and data per width
// (R9) single chip mode or four external bus modes with 16-22 address bits
// (R10) wait states, tri-state, latch pulse and strobe delay are programmable
// (R11) four address windows each with range and bus configuration
// (R12) window four beats three, window two beats one
// (R13) accesses outside all windows use the default configuration
// (R14) four chip selects: three windows plus default region
// (R15) unlatched mode decodes chip selects directly from the current address
// (R16) upper address pins output six, four, two or no lines
// (R17) chip selects active low, stable through the cycle when latched
module ebu_ctrl (
	// clock and reset
	input  wire logic                      mclk_i,
	input  wire logic                      rst_n_i,
	// configuration
	input  wire ebu_pkg::ebu_sys_t         sys_i,
	input  wire ebu_pkg::ebu_cfg_t         default_bus_config_i,
	input  wire ebu_pkg::ebu_cfg_t [3:0]   window_bus_config_i,
	input  wire ebu_pkg::ebu_win_t [3:0]   window_range_i,
	input  wire logic [15:0]               port_dir_i,
	input  wire logic [15:0]               port_out_i,
	input  wire logic                      external_fetch_select_n_i,
	// core request
	input  wire ebu_pkg::ebu_req_t         req_i,
	output logic                           req_ready_o,
	output logic                           rvalid_o,
	output logic [15:0]                    rdata_o,
	output logic                           fetch_external_o,
	// external pins
	input  wire logic [15:0]               primary_bus_pins_i,
	output logic [15:0]                    primary_bus_pins_o,
	output logic [15:0]                    primary_bus_pins_oe_o,
	output logic [15:0]                    secondary_address_pins_o,
	output logic [5:0]                     upper_address_o,
	output logic                           read_strobe_n_o,
	output logic                           store_strobe_n_o,
	output logic                           addr_latch_o,
	output logic [3:0]                     chip_select_n_o
);

	typedef enum logic [2:0] {
		ST_IDLE   = 3'h0,
		ST_ALE    = 3'h1,
		ST_DELAY  = 3'h2,
		ST_STROBE = 3'h3,
		ST_TRI    = 3'h4
	} ebu_state_t;

	ebu_state_t         state;
	ebu_state_t         next_state;
	ebu_pkg::ebu_req_t  cur;
	ebu_pkg::ebu_cfg_t  cfg;
	ebu_pkg::ebu_cfg_t  sel_cfg;
	logic [3:0]         sel_cs_n;
	logic [3:0]         cnt;
	logic [3:0]         next_cnt;
	logic [3:0]         win_hit;
	logic               mux_mode;
	logic               wide;
	logic               start;
	logic               strap_caught;
	ebu_pkg::ebu_req_t  live_req;
	ebu_pkg::ebu_cfg_t  live_cfg;

	// window match per window, one comparator each
	genvar gi;
	generate
		for (gi = 0; gi < ebu_pkg::NWIN; gi++) begin : g_win
			assign win_hit[gi] = window_range_i[gi].enable &&
				(((req_i.addr[ebu_pkg::ADDR_W-1:ebu_pkg::WIN_LSB] ^ window_range_i[gi].base)
				& window_range_i[gi].mask) == '0);
		end
	endgenerate

	// priority decode; one chain, window four checked first, then three, two and one
	always_comb begin
		sel_cfg  = default_bus_config_i; // [R13]
		sel_cs_n = 4'h7;                 // default region select [R14]
		if (win_hit[3]) begin
			sel_cfg  = window_bus_config_i[3]; // [R11] [R12]
			sel_cs_n = 4'hb;
		end else if (win_hit[2]) begin
			sel_cfg  = window_bus_config_i[2];
			sel_cs_n = 4'hb;                   // window three shares the third select
		end else if (win_hit[1]) begin
			sel_cfg  = window_bus_config_i[1]; // [R12]
			sel_cs_n = 4'hd;
		end else if (win_hit[0]) begin
			sel_cfg  = window_bus_config_i[0];
			sel_cs_n = 4'he;
		end
	end

	assign start    = req_i.valid && (state == ST_IDLE) &&
		(sel_cfg.mode != ebu_pkg::EBU_MODE_SINGLE); // [R9]
	// the cycle just starting uses the live request, later phases the held copy
	assign live_req = start ? req_i : cur;
	assign live_cfg = start ? sel_cfg : cfg;
	assign mux_mode = (live_cfg.mode == ebu_pkg::EBU_MODE_MUX16) ||
		(live_cfg.mode == ebu_pkg::EBU_MODE_MUX8);
	assign wide     = (live_cfg.mode == ebu_pkg::EBU_MODE_MUX16) ||
		(live_cfg.mode == ebu_pkg::EBU_MODE_DEMUX16);

	// strap caught at the first clock after reset release, held thereafter
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			strap_caught     <= 1'b0;
			fetch_external_o <= 1'b0;
		end else if (!strap_caught) begin
			strap_caught     <= 1'b1;
			fetch_external_o <= !external_fetch_select_n_i; // [R5]
		end
	end

	// next-state logic; counters load timing fields per phase
	always_comb begin
		next_state = state;
		next_cnt   = cnt;
		case (state)
			ST_IDLE: begin
				if (start) begin
					next_state = ST_ALE;
					next_cnt   = {2'h0, sel_cfg.ale_cyc}; // [R10]
				end
			end
			ST_ALE: begin
				if (cnt == ebu_pkg::CNT_ZERO) begin
					next_state = ST_DELAY;
					next_cnt   = {2'h0, cfg.strobe_dly};
				end else begin
					next_cnt = cnt - ebu_pkg::CNT_ONE;
				end
			end
			ST_DELAY: begin
				if (cnt == ebu_pkg::CNT_ZERO) begin
					next_state = ST_STROBE;
					next_cnt   = cfg.wait_cyc;
				end else begin
					next_cnt = cnt - ebu_pkg::CNT_ONE;
				end
			end
			ST_STROBE: begin
				if (cnt == ebu_pkg::CNT_ZERO) begin
					next_state = ST_TRI;
					next_cnt   = {2'h0, cfg.tri_cyc};
				end else begin
					next_cnt = cnt - ebu_pkg::CNT_ONE;
				end
			end
			ST_TRI: begin
				if (cnt == ebu_pkg::CNT_ZERO) begin
					next_state = ST_IDLE;
				end else begin
					next_cnt = cnt - ebu_pkg::CNT_ONE;
				end
			end
			default: begin
				next_state = ST_IDLE;
				next_cnt   = ebu_pkg::CNT_ZERO;
			end
		endcase
	end

	// sequencer state
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			state <= ST_IDLE;
			cnt   <= ebu_pkg::CNT_ZERO;
		end else begin
			state <= next_state;
			cnt   <= next_cnt;
		end
	end

	// request and configuration captured at start, held for the whole cycle
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			cur <= '0;
			cfg <= '0;
		end else if (start) begin
			cur <= req_i;
			cfg <= sel_cfg;
		end
	end

	// ready only in idle: the core waits through the whole bus cycle
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			req_ready_o <= 1'b0;
		end else begin
			req_ready_o <= (next_state == ST_IDLE) && !start;
		end
	end

	// read data captured as the strobe ends
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			rvalid_o <= 1'b0;
			rdata_o  <= '0;
		end else begin
			rvalid_o <= 1'b0;
			if (state == ST_STROBE && cnt == ebu_pkg::CNT_ZERO && !cur.write) begin
				rvalid_o <= 1'b1;
				rdata_o  <= wide ? primary_bus_pins_i :
					{8'h00, primary_bus_pins_i[ebu_pkg::HALF_W-1:0]};
			end
		end
	end

	// strobes and latch pulse
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			read_strobe_n_o  <= 1'b1;
			store_strobe_n_o <= 1'b1;
			addr_latch_o     <= 1'b0;
		end else begin
			addr_latch_o    <= (next_state == ST_ALE) && mux_mode; // [R4]
			read_strobe_n_o <= !((next_state == ST_STROBE) && !live_req.write); // [R1]
			// low-byte mode needs the low byte on a wide bus
			store_strobe_n_o <= !((next_state == ST_STROBE) && live_req.write &&
				(!sys_i.low_byte_store_mode || !wide || live_req.be[0])); // [R2] [R3]
		end
	end

	// chip selects: latched per cycle, or straight from the live address
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			chip_select_n_o <= ebu_pkg::CS_IDLE;
		end else if (sys_i.unlatched_select_bit) begin
			chip_select_n_o <= req_i.valid ? sel_cs_n : ebu_pkg::CS_IDLE; // [R15]
		end else if (start) begin
			chip_select_n_o <= sel_cs_n; // [R17]
		end else if (next_state == ST_IDLE) begin
			chip_select_n_o <= ebu_pkg::CS_IDLE; // [R17]
		end
	end

	// pin drive: address phase, then data phase; port logic when idle
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			primary_bus_pins_o       <= '0;
			primary_bus_pins_oe_o    <= '0;
			secondary_address_pins_o <= '0;
			upper_address_o          <= '0;
		end else if (next_state == ST_IDLE) begin
			primary_bus_pins_o    <= port_out_i;
			primary_bus_pins_oe_o <= port_dir_i; // input bits left undriven [R6]
		end else begin
			secondary_address_pins_o <= mux_mode ? '0 : live_req.addr[15:0]; // [R7]
			for (int i = 0; i < ebu_pkg::UPPER_W; i++) begin
				upper_address_o[i] <= (3'(i) < upper_lines()) &&
					live_req.addr[ebu_pkg::UPPER_LSB + i]; // [R16]
			end
			if (mux_mode && next_state == ST_ALE) begin
				primary_bus_pins_o    <= live_req.addr[15:0]; // [R8]
				primary_bus_pins_oe_o <= 16'hffff;
			end else if (mux_mode && !wide) begin
				primary_bus_pins_o    <= {live_req.addr[15:8], live_req.wdata[7:0]}; // [R8]
				primary_bus_pins_oe_o <= {8'hff, {8{live_req.write && next_state == ST_STROBE}}};
			end else begin
				primary_bus_pins_o    <= wide ? live_req.wdata :
					{8'h00, live_req.wdata[7:0]}; // [R7]
				primary_bus_pins_oe_o <= {{8{live_req.write && wide && next_state == ST_STROBE}},
					{8{live_req.write && next_state == ST_STROBE}}};
			end
		end
	end

	function automatic logic [2:0] upper_lines();
		case (sys_i.space)
			ebu_pkg::EBU_SPACE_1M:   upper_lines = ebu_pkg::UPPER_1M;
			ebu_pkg::EBU_SPACE_256K: upper_lines = ebu_pkg::UPPER_256K;
			ebu_pkg::EBU_SPACE_64K:  upper_lines = ebu_pkg::UPPER_64K;
			default:                 upper_lines = ebu_pkg::UPPER_4M;
		endcase
	endfunction : upper_lines

	// a read strobe is never seen on a write cycle
	property p_rd_not_write;
		@(posedge mclk_i) disable iff (!rst_n_i)
		(state == ST_STROBE && cur.write) |-> read_strobe_n_o;
	endproperty
	a_rd_not_write: assert property (p_rd_not_write) else $error("read strobe on write"); // [R1]

	// plain store mode: every write cycle shows the store strobe
	property p_store_plain;
		@(posedge mclk_i) disable iff (!rst_n_i)
		(state == ST_STROBE && cur.write && !sys_i.low_byte_store_mode) |-> !store_strobe_n_o;
	endproperty
	a_store_plain: assert property (p_store_plain) else $error("missing store strobe"); // [R2]

	// low-byte mode on a wide bus: high-byte-only writes give no strobe
	property p_store_low;
		@(posedge mclk_i) disable iff (!rst_n_i)
		(state == ST_STROBE && sys_i.low_byte_store_mode && wide && !cur.be[0]) |->
			store_strobe_n_o;
	endproperty
	a_store_low: assert property (p_store_low) else $error("store strobe on high byte"); // [R3]

	// latch pulse only in multiplexed modes
	property p_ale_mux;
		@(posedge mclk_i) disable iff (!rst_n_i)
		addr_latch_o |-> mux_mode;
	endproperty
	a_ale_mux: assert property (p_ale_mux) else $error("latch pulse in demux mode"); // [R4]

	// input-direction bits are undriven while idle
	property p_dir_idle;
		@(posedge mclk_i) disable iff (!rst_n_i)
		(state == ST_IDLE && $past(state) == ST_IDLE && $stable(port_dir_i)) |->
			((primary_bus_pins_oe_o & ~port_dir_i) == '0);
	endproperty
	a_dir_idle: assert property (p_dir_idle) else $error("input bit driven"); // [R6]

	// single chip mode starts no cycle
	property p_single;
		@(posedge mclk_i) disable iff (!rst_n_i)
		(state == ST_IDLE && sel_cfg.mode == ebu_pkg::EBU_MODE_SINGLE) |=> state == ST_IDLE;
	endproperty
	a_single: assert property (p_single) else $error("cycle in single chip mode"); // [R9]

	// a latched select holds during the cycle
	property p_cs_stable;
		@(posedge mclk_i) disable iff (!rst_n_i)
		(!sys_i.unlatched_select_bit && state != ST_IDLE && next_state != ST_IDLE &&
			$stable(sys_i)) |=> $stable(chip_select_n_o);
	endproperty
	a_cs_stable: assert property (p_cs_stable) else $error("chip select moved"); // [R17]

	// in 64K space every upper line stays low
	property p_upper;
		@(posedge mclk_i) disable iff (!rst_n_i)
		(sys_i.space == ebu_pkg::EBU_SPACE_64K && $stable(sys_i)) |=> upper_address_o == '0;
	endproperty
	a_upper: assert property (p_upper) else $error("upper lines in 64K space"); // [R16]

endmodule : ebu_ctrl

`default_nettype wire

// *** dv/ebu_mem_model.sv ***
`timescale 1ns/1ns
`default_nettype none
module ebu_mem_model (
	// clock and bus form
	input  wire logic        mclk_i,
	input  wire logic        mux_i,
	// pins seen from the memory side
	input  wire logic [15:0] bus_out_i,
	input  wire logic [15:0] addr_i,
	input  wire logic        rd_n_i,
	input  wire logic        wr_n_i,
	input  wire logic        ale_i,
	output logic      [15:0] bus_in_o
);
	logic [15:0] mem [256];
	logic [7:0]  a;

	initial bus_in_o = 16'h0000;

	// address capture on the latch pulse or from the address pins
	always @(posedge mclk_i) begin
		if (mux_i && ale_i) a <= bus_out_i[7:0];
		if (!mux_i) a <= addr_i[7:0];
		if (!wr_n_i) mem[a] <= bus_out_i;
	end

	// released lines toggle so stale read data never passes for a match
	always @(negedge mclk_i) bus_in_o <= !rd_n_i ? mem[a] : ~bus_in_o;
endmodule : ebu_mem_model
`default_nettype wire

// *** dv/external_memory_bus_controller_test.sv ***
`timescale 1ns/1ns
`default_nettype none
module external_memory_bus_controller_test;
	logic                    mclk_i = 1'b0;
	logic                    rst_n_i = 1'b0;
	ebu_pkg::ebu_sys_t       sys = '0;
	ebu_pkg::ebu_cfg_t       dcfg = '0;
	ebu_pkg::ebu_cfg_t       c = '0;
	ebu_pkg::ebu_cfg_t [3:0] wcfg = '0;
	ebu_pkg::ebu_win_t [3:0] win = '0;
	ebu_pkg::ebu_req_t       req = '0;
	logic [15:0]             pdir = 16'h00ff;
	logic [15:0]             pout = 16'h1234;
	logic                    strap = 1'b0;
	logic                    rdy, rv, fext, rdn, wrn, ale;
	logic [15:0]             rdat, pi, po, poe, sec, d;
	logic [5:0]              up;
	logic [3:0]              csn;
	logic [21:0]             a;
	logic [21:0]             wa [5] = '{22'h00_0000, 22'h00_0400, 22'h00_4000, 22'h00_4400, 22'h10_0000};
	logic [3:0]              wc [5] = '{4'he, 4'hd, 4'hb, 4'hb, 4'h7};
	int                      fails = 0;
	int                      n_compared = 0;
	int                      cyc = 0;

	always #50 mclk_i = ~mclk_i;

	ebu_ctrl uut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .sys_i(sys), .default_bus_config_i(dcfg),
		.window_bus_config_i(wcfg), .window_range_i(win), .port_dir_i(pdir), .port_out_i(pout),
		.external_fetch_select_n_i(strap), .req_i(req), .req_ready_o(rdy), .rvalid_o(rv),
		.rdata_o(rdat), .fetch_external_o(fext), .primary_bus_pins_i(pi),
		.primary_bus_pins_o(po), .primary_bus_pins_oe_o(poe), .secondary_address_pins_o(sec),
		.upper_address_o(up), .read_strobe_n_o(rdn), .store_strobe_n_o(wrn),
		.addr_latch_o(ale), .chip_select_n_o(csn));

	ebu_mem_model mdl (.mclk_i(mclk_i), .mux_i(dcfg.mode inside {ebu_pkg::EBU_MODE_MUX16,
		ebu_pkg::EBU_MODE_MUX8}), .bus_out_i(po), .addr_i(sec), .rd_n_i(rdn), .wr_n_i(wrn),
		.ale_i(ale), .bus_in_o(pi));

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic test_done();
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : test_done

	// hang guard, far above the few hundred cycles the tests need
	always @(posedge mclk_i) begin
		cyc++;
		if (cyc == 8000) begin
			fails++;
			test_done();
		end
	end

	task automatic reset(input logic s);
		@(negedge mclk_i);
		rst_n_i = 1'b0;
		strap = s;
		repeat (4) @(negedge mclk_i);
		rst_n_i = 1'b1;
		repeat (2) @(negedge mclk_i);
		check("fetch_external", fext, !s);
	endtask : reset

	function automatic logic [5:0] upm(input ebu_pkg::ebu_space_t s);
		return (s == ebu_pkg::EBU_SPACE_4M) ? 6'h3f : (s == ebu_pkg::EBU_SPACE_1M) ? 6'h0f :
			(s == ebu_pkg::EBU_SPACE_256K) ? 6'h03 : 6'h00;
	endfunction : upm

	// one whole access; pins are watched at every falling edge until ready returns
	task automatic xfer(input logic wr, input logic f, input logic [1:0] be, input logic [21:0] ad,
			input logic [15:0] wd, input ebu_pkg::ebu_cfg_t cf, input logic [3:0] cs,
			input logic wexp);
		int n = 0, rl = 0, wl = 0, al = 0, lat = 0, bad = 0;
		logic mux, w8;
		mux = cf.mode inside {ebu_pkg::EBU_MODE_MUX16, ebu_pkg::EBU_MODE_MUX8};
		w8 = cf.mode inside {ebu_pkg::EBU_MODE_MUX8, ebu_pkg::EBU_MODE_DEMUX8};
		@(negedge mclk_i);
		req = '{1'b1, wr, f, be, ad, wd};
		while (n < 100) begin
			@(negedge mclk_i);
			n++;
			if (rdy === 1'b1 && n > 1) break;
			if (!rdn) rl++;
			if (!wrn) wl++;
			if (ale) al++;
			if (rv) begin
				lat = n;
				d = rdat;
			end
			if (ale && po !== ad[15:0]) bad++;
			if ((!rdn || !wrn) && (csn !== cs || up !== (ad[21:16] & upm(sys.space)))) bad++;
			if ((!rdn || !wrn) && !mux && sec !== ad[15:0]) bad++;
			if ((!rdn || !wrn) && mux && w8 && po[15:8] !== ad[15:8]) bad++;
			if (!rdn && poe[7:0] !== 8'h00) bad++;
			if (!wrn && (poe[7:0] !== 8'hff || po[7:0] !== wd[7:0])) bad++;
			if (!wrn && !w8 && po[15:8] !== wd[15:8]) bad++;
		end
		req.valid = 1'b0;
		check("ready_back", n < 100, 1);
		check("cycle_len", n, cf.ale_cyc + cf.strobe_dly + cf.wait_cyc + cf.tri_cyc + 5);
		check("read_strobe", rl, wr ? 0 : cf.wait_cyc + 1);
		check("store_strobe", wl, wexp ? cf.wait_cyc + 1 : 0);
		check("latch_pulse", al, mux ? cf.ale_cyc + 1 : 0);
		check("pins", bad, 0);
		if (!wr) check("latency", lat, cf.ale_cyc + cf.strobe_dly + cf.wait_cyc + 4);
		if (!wr) check("rdata", w8 ? d[7:0] : d, w8 ? wd[7:0] : wd);
	endtask : xfer

	// main sequence
	initial begin
		reset(1'b1);
		reset(1'b0);
		req = '{1'b1, 1'b0, 1'b0, 2'h3, 22'h00_0100, 16'h0000};
		repeat (8) @(negedge mclk_i);
		check("single_ready", rdy, 1'b1);
		check("single_strobes", {rdn, wrn, ale}, 3'h6);
		check("port_dir", poe, pdir);
		req.valid = 1'b0;
		$display("test single chip done");
		// every external mode, every space restriction, two-bit timing fields at both ends, wait counts one to four
		for (int m = 1; m <= 4; m++) begin
			dcfg = '{ebu_pkg::ebu_mode_t'(m), 4'(m), 2'(m - 1), 2'(m - 1), 2'(4 - m)};
			sys.space = ebu_pkg::ebu_space_t'(m - 1);
			a = {6'h2d, 8'hc3, 8'(m * 4)};
			xfer(1, 0, 2'h3, a, 16'ha5c0 + 16'(m), dcfg, 4'h7, 1);
			xfer(0, m[0], 2'h3, a, 16'ha5c0 + 16'(m), dcfg, 4'h7, 0);
			$display("test mode %0d done", m);
		end
		// low-byte store mode on 8-bit then 16-bit bus
		sys.low_byte_store_mode = 1'b1;
		xfer(1, 0, 2'h2, a, 16'h0f0f, dcfg, 4'h7, 1);
		dcfg.mode = ebu_pkg::EBU_MODE_DEMUX16;
		for (int k = 1; k < 4; k++) xfer(1, 0, 2'(k), a, 16'h0f0f, dcfg, 4'h7, k[0]);
		sys.low_byte_store_mode = 1'b0;
		$display("test low byte store done");
		// overlapping windows, each with its own wait count
		win[0] = '{1'b1, 12'h001, 12'hffe};
		win[1] = '{1'b1, 12'h001, 12'hfff};
		win[2] = '{1'b1, 12'h010, 12'hff0};
		win[3] = '{1'b1, 12'h011, 12'hfff};
		for (int i = 0; i < 4; i++) wcfg[i] = '{ebu_pkg::EBU_MODE_DEMUX16, 4'(i + 2), 2'h1, 2'h0, 2'h0};
		for (int k = 0; k < 5; k++) begin
			c = (k < 4) ? wcfg[k] : dcfg;
			xfer(1, 0, 2'h3, wa[k], 16'h3c00 + 16'(k), c, wc[k], 1);
			xfer(0, 0, 2'h3, wa[k], 16'h3c00 + 16'(k), c, wc[k], 0);
		end
		$display("test windows done");
		// unlatched selects follow the request directly
		sys.unlatched_select_bit = 1'b1;
		xfer(1, 0, 2'h3, wa[1], 16'h3c01, wcfg[1], 4'hd, 1);
		xfer(0, 0, 2'h3, wa[1], 16'h3c01, wcfg[1], 4'hd, 0);
		repeat (2) @(negedge mclk_i);
		check("unlatched_idle", csn, 4'hf);
		$display("test unlatched done");
		test_done();
	end
endmodule : external_memory_bus_controller_test
`default_nettype wire
